// ---- sdc_params.svh ----
// constants of the upper card command interpreter
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

`define SDC_IDX_SET_WP 6'h1C
`define SDC_IDX_CLR_WP 6'h1D
`define SDC_IDX_SEND_WP 6'h1E
`define SDC_IDX_ERASE_START 6'h23
`define SDC_IDX_ERASE_END 6'h24
`define SDC_IDX_ERASE 6'h26
`define SDC_IDX_FAST_IO 6'h27
`define SDC_IDX_IRQ_STATE 6'h28
`define SDC_IDX_LOCK 6'h2A
`define SDC_IDX_APP_CMD 6'h37
`define SDC_IDX_GEN_CMD 6'h38

`define SDC_FRAME_LEN 7'h30
`define SDC_RESP_LAST 7'h2F
`define SDC_RESP_IDX_HI 45
`define SDC_RESP_IDX_LO 40
`define SDC_ARG_HI 39
`define SDC_ARG_LO 8
`define SDC_CRC_POLY 7'h09
`define SDC_NCR_MAX 7'h40

`endif

// ---- sdc_pkg.sv ----
// types of the upper card command interpreter
package sdc_pkg;

  typedef enum logic [1:0] {
    SDC_AC = 2'h0,
    SDC_ADTC = 2'h1,
    SDC_BCR = 2'h2
  } sdc_kind_t;

  typedef enum logic [1:0] {
    SDC_R1 = 2'h0,
    SDC_R1B = 2'h1,
    SDC_R4 = 2'h2,
    SDC_R5 = 2'h3
  } sdc_resp_t;

  // gray path: idle -> send -> resp -> data -> idle
  typedef enum logic [1:0] {
    SDC_IDLE = 2'h0,
    SDC_SEND = 2'h1,
    SDC_RESP = 2'h3,
    SDC_DATA = 2'h2
  } sdc_state_t;

  typedef struct packed {
    logic [5:0] index;
    logic [31:0] addr;
    logic [15:0] rca;
    logic wflag;
    logic [6:0] reg_addr;
    logic [7:0] wdata;
    logic dir;
  } sdc_req_t;

  typedef struct packed {
    logic legal;
    sdc_kind_t kind;
    sdc_resp_t resp;
    logic busy;
    logic data;
  } sdc_info_t;

  typedef struct packed {
    logic [5:0] index;
    logic [31:0] status;
    logic err;
  } sdc_answer_t;

endpackage

// ---- sdc_cmd_decode.sv ----
// command classifier and argument packer
`timescale 1ns/1ps
`include "sdc_params.svh"

module sdc_cmd_decode (
  input wire sdc_pkg::sdc_req_t req,
  output sdc_pkg::sdc_info_t info,
  output logic [31:0] arg
);

  always_comb begin
    info = '{legal: 1'b1, kind: sdc_pkg::SDC_AC, resp: sdc_pkg::SDC_R1, busy: 1'b0, data: 1'b0};
    arg = req.addr;
    unique case (req.index)
      `SDC_IDX_SET_WP, `SDC_IDX_CLR_WP: begin
        info.resp = sdc_pkg::SDC_R1B;
        info.busy = 1'b1;
      end
      `SDC_IDX_SEND_WP: begin
        info.kind = sdc_pkg::SDC_ADTC; // [R3]
        info.data = 1'b1;
      end
      `SDC_IDX_ERASE_START, `SDC_IDX_ERASE_END: begin
        info.kind = sdc_pkg::SDC_AC;
      end
      `SDC_IDX_ERASE: begin
        arg = 32'h0000_0000;
        info.resp = sdc_pkg::SDC_R1B;
        info.busy = 1'b1;
      end
      `SDC_IDX_FAST_IO: begin
        arg = {req.rca, req.wflag, req.reg_addr, req.wdata}; // [R8]
        info.resp = sdc_pkg::SDC_R4;
      end
      `SDC_IDX_IRQ_STATE: begin
        arg = 32'h0000_0000; // [R10]
        info.kind = sdc_pkg::SDC_BCR;
        info.resp = sdc_pkg::SDC_R5;
      end
      `SDC_IDX_LOCK: begin
        arg = 32'h0000_0000; // [R11]
        info.kind = sdc_pkg::SDC_ADTC;
        info.resp = sdc_pkg::SDC_R1B;
        info.busy = 1'b1;
        info.data = 1'b1;
      end
      `SDC_IDX_APP_CMD: begin
        arg = {req.rca, 16'h0000}; // [R12]
      end
      `SDC_IDX_GEN_CMD: begin
        arg = {31'h0000_0000, req.dir}; // [R13]
        info.kind = sdc_pkg::SDC_ADTC;
        info.resp = sdc_pkg::SDC_R1B;
        info.busy = 1'b1;
        info.data = 1'b1;
      end
      default: begin
        // reserved and out-of-range indices are never put on the line
        info.legal = 1'b0; // [R4]
      end
    endcase
  end

endmodule

// ---- sdc_cmd_upper.sv ----
// host-side interpreter for card commands 28 to 63
`timescale 1ns/1ps
`include "sdc_params.svh"

// Functional notes
// R1 - On 28 the card sets the write-protect bit of the addressed group and answers busy-capable.
// R2 - On 29 the card clears the write-protect bit of the addressed group and answers busy-capable.
// R3 - Index 30 is an addressed data command returning protection bits with a normal response.
// R4 - The host never issues 31 to 34, 37, 41, 43 to 54 or 57 to 59.
// R5 - On 35 the card records the argument as the first erase group.
// R6 - On 36 the card records the argument as the last erase group.
// R7 - On 38 the card erases every previously selected write block.
// R8 - For 39 the argument packs address, write flag, register address and write data.
// R9 - On 39 the card writes the register when flagged and returns its contents.
// R10 - Index 40 is broadcast with response, stuff argument, interrupt-request answer.
// R11 - Index 42 is an addressed data command with busy-capable answer for lock and password.
// R12 - Index 55 carries the relative address in the top half and prefixes the next command.
// R13 - Index 56 moves one general block, direction in argument bit 0.
// R14 - Addressed commands without data move nothing; data commands start a data transfer.
// R15 - The normal response is 48 bits with the answered index in bits 45 to 40.
// R16 - The busy-capable response adds a busy level on the data line afterwards.
// R17 - After a busy-capable response no data command starts until the data line is released; the host also ends the wait at any later non-busy response.
module sdc_cmd_upper (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic req_valid,
  output logic req_ready,
  input wire sdc_pkg::sdc_req_t req,
  output logic done,
  output logic refused,
  output sdc_pkg::sdc_answer_t answer,
  output logic busy_pending,
  output logic data_start,
  output logic data_dir,
  input wire logic data_done,
  input wire logic sd_clk,
  input wire logic cmd_i,
  output logic cmd_o,
  output logic cmd_oe_n,
  input wire logic dat0_i
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    sdc_pkg::sdc_state_t st;
    logic [6:0] cnt;
    logic [6:0] tmo;
    logic [47:0] sh;
    sdc_pkg::sdc_info_t info;
    logic [5:0] idx;
    logic busy_pend;
    logic cmd_o;
    logic cmd_oe_n;
    logic done;
    logic refused;
    logic data_start;
    logic data_dir;
    sdc_pkg::sdc_answer_t ans;
    logic [2:0] clk_s;
    logic [1:0] cmd_s;
    logic [1:0] dat_s;
  } sdc_regs_t;

  sdc_regs_t q, d;
  sdc_pkg::sdc_info_t info_in;
  logic [31:0] arg_in;
  logic acc, clk_rise, clk_fall;
  logic [47:0] rx_next;

  sdc_cmd_decode u_dec (
    .req(req),
    .info(info_in),
    .arg(arg_in)
  );

  // crc7 over the 40 leading bits of a command frame
  function automatic logic [6:0] crc7(input logic [39:0] bits);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = c[6] ^ bits[i];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ `SDC_CRC_POLY;
      end
    end
    return c;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // data commands stall while a card may still hold the line busy
  assign req_ready = (q.st == sdc_pkg::SDC_IDLE) && !(info_in.data && q.busy_pend); // [R17]
  assign acc = req_valid && req_ready;
  // only the second and third stages of the clock sampler are looked at
  assign clk_rise = q.clk_s[1] && !q.clk_s[2];
  assign clk_fall = !q.clk_s[1] && q.clk_s[2];
  assign rx_next = {q.sh[46:0], q.cmd_s[1]};

  always_comb begin
    d = q;
    d.clk_s = {q.clk_s[1:0], sd_clk};
    d.cmd_s = {q.cmd_s[0], cmd_i};
    d.dat_s = {q.dat_s[0], dat0_i};
    d.done = 1'b0;
    d.refused = 1'b0;
    d.data_start = 1'b0;
    unique case (q.st)
      sdc_pkg::SDC_IDLE: begin
        d.cmd_oe_n = 1'b1;
        if (q.dat_s[1]) begin
          d.busy_pend = 1'b0; // [R17]
        end
        if (acc && !info_in.legal) begin
          d.refused = 1'b1; // [R4]
        end else if (acc) begin
          d.sh = {2'b01, req.index, arg_in, crc7({2'b01, req.index, arg_in}), 1'b1};
          d.info = info_in;
          d.idx = req.index;
          d.data_dir = req.dir;
          d.cnt = 7'h00;
          d.st = sdc_pkg::SDC_SEND;
        end
      end
      sdc_pkg::SDC_SEND: begin
        if (clk_fall) begin
          if (q.cnt == `SDC_FRAME_LEN) begin
            d.cmd_oe_n = 1'b1;
            d.cnt = 7'h00;
            d.tmo = 7'h00;
            d.st = sdc_pkg::SDC_RESP;
          end else begin
            d.cmd_o = q.sh[47];
            d.cmd_oe_n = 1'b0;
            d.sh = {q.sh[46:0], 1'b0};
            d.cnt = q.cnt + 7'h01;
          end
        end
      end
      sdc_pkg::SDC_RESP: begin
        if (clk_rise) begin
          if (q.cnt == 7'h00 && q.cmd_s[1]) begin
            d.tmo = q.tmo + 7'h01;
            if (q.tmo == `SDC_NCR_MAX) begin
              d.ans.err = 1'b1;
              d.done = 1'b1;
              d.st = sdc_pkg::SDC_IDLE;
            end
          end else begin
            d.sh = rx_next;
            d.cnt = q.cnt + 7'h01;
            if (q.cnt == `SDC_RESP_LAST) begin
              d.ans.index = rx_next[`SDC_RESP_IDX_HI:`SDC_RESP_IDX_LO]; // [R15]
              d.ans.status = rx_next[`SDC_ARG_HI:`SDC_ARG_LO];
              d.ans.err = rx_next[`SDC_RESP_IDX_HI:`SDC_RESP_IDX_LO] != q.idx;
              if (q.info.data) begin
                d.data_start = 1'b1; // [R14]
                d.st = sdc_pkg::SDC_DATA;
              end else begin
                d.done = 1'b1;
                d.busy_pend = q.info.busy; // [R16]
                d.st = sdc_pkg::SDC_IDLE;
              end
            end
          end
        end
      end
      sdc_pkg::SDC_DATA: begin
        if (data_done) begin
          d.done = 1'b1;
          d.busy_pend = q.info.busy; // [R11]
          d.st = sdc_pkg::SDC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      // enum members named outright so the fill never lands on an enum
      q <= '{st: sdc_pkg::SDC_IDLE, cmd_oe_n: 1'b1, cmd_o: 1'b1, clk_s: 3'h0,
             cmd_s: 2'h3, dat_s: 2'h3,
             info: '{legal: 1'b0, kind: sdc_pkg::SDC_AC, resp: sdc_pkg::SDC_R1,
                     busy: 1'b0, data: 1'b0},
             default: '0};
    end else begin
      q <= d;
    end
  end

  assign done = q.done;
  assign refused = q.refused;
  assign answer = q.ans;
  assign busy_pending = q.busy_pend;
  assign data_start = q.data_start;
  assign data_dir = q.data_dir;
  assign cmd_o = q.cmd_o;
  assign cmd_oe_n = q.cmd_oe_n;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_rsv_refused;
    acc && !info_in.legal |=> refused && q.st == sdc_pkg::SDC_IDLE;
  endproperty
  a_rsv_refused: assert property (p_rsv_refused) else $error("reserved index not refused"); // [R4]

  property p_fastio_arg;
    acc && req.index == `SDC_IDX_FAST_IO |=>
      q.sh[39:8] == {$past(req.rca), $past(req.wflag), $past(req.reg_addr), $past(req.wdata)};
  endproperty
  a_fastio_arg: assert property (p_fastio_arg) else $error("fast io argument misplaced"); // [R8]

  property p_app_arg;
    acc && req.index == `SDC_IDX_APP_CMD |=> q.sh[39:8] == {$past(req.rca), 16'h0000};
  endproperty
  a_app_arg: assert property (p_app_arg) else $error("app prefix argument wrong"); // [R12]

  property p_gen_arg;
    acc && req.index == `SDC_IDX_GEN_CMD |=> q.sh[39:9] == 31'h0 && q.sh[8] == $past(req.dir);
  endproperty
  a_gen_arg: assert property (p_gen_arg) else $error("general command direction wrong"); // [R13]

  property p_irq_bcr;
    acc && req.index == `SDC_IDX_IRQ_STATE |=>
      q.info.kind == sdc_pkg::SDC_BCR && q.info.resp == sdc_pkg::SDC_R5 && q.sh[39:8] == 32'h0;
  endproperty
  a_irq_bcr: assert property (p_irq_bcr) else $error("interrupt state command malformed"); // [R10]

  property p_sendwp_data;
    acc && req.index == `SDC_IDX_SEND_WP |=> q.info.data && q.info.resp == sdc_pkg::SDC_R1;
  endproperty
  a_sendwp_data: assert property (p_sendwp_data) else $error("protect query not a data command"); // [R3]

  property p_data_only_adtc;
    data_start |-> q.info.kind == sdc_pkg::SDC_ADTC && q.st == sdc_pkg::SDC_DATA;
  endproperty
  a_data_only_adtc: assert property (p_data_only_adtc) else $error("data phase on non data command"); // [R14]

  property p_busy_stall;
    q.st == sdc_pkg::SDC_IDLE && q.busy_pend && info_in.data |-> !req_ready;
  endproperty
  a_busy_stall: assert property (p_busy_stall) else $error("data command taken while busy"); // [R17]

  property p_lock_busy;
    done && q.info.busy && !q.ans.err |-> busy_pending;
  endproperty
  a_lock_busy: assert property (p_lock_busy) else $error("busy wait not armed"); // [R11]

  c_data_cmd: cover property (data_start ##[1:1000] done);
  c_refused: cover property (refused);
  c_busy_stall: cover property (req_valid && !req_ready && q.st == sdc_pkg::SDC_IDLE);

endmodule

// ---- sdc_card_model.sv ----
// card-side model that answers frames on the command line
`timescale 1ns/1ps
module sdc_card_model (
  input wire logic sclk,
  input wire logic host_bit,
  input wire logic host_drive_n,
  input wire logic [1:0] mode,
  output logic line,
  output logic dat0,
  output logic [47:0] frame
);
  // ------------------------------
  // frame capture and response
  // ------------------------------
  logic [47:0] rsp;
  logic [7:0] regs [0:127];
  logic [127:0] wp;
  logic [31:0] arg;
  logic [31:0] erase_lo;
  logic [31:0] erase_hi;
  logic [5:0] idx;
  int n;
  int falls = 0;
  int busy_end = 0;
  // busy counted in clock falls apart so the next frame is never missed
  assign dat0 = (falls >= busy_end);
  always @(negedge sclk) begin
    falls++;
  end
  initial begin
    line = 1'b1;
    frame = '0;
    wp = '0;
    n = 0;
    forever begin
      @(posedge sclk iff !host_drive_n);
      frame = {frame[46:0], host_bit};
      n++;
      if (n == 48) begin
        n = 0;
        idx = frame[45:40];
        arg = frame[39:8];
        case (idx)
          6'h1C: wp[arg[6:0]] = 1'b1;
          6'h1D: wp[arg[6:0]] = 1'b0;
          6'h23: erase_lo = arg;
          6'h24: erase_hi = arg;
          6'h26: erase_lo = 32'h0;
          6'h27: begin
            if (arg[15]) regs[arg[14:8]] = arg[7:0];
            arg[7:0] = regs[arg[14:8]];
          end
          default: ;
        endcase
        repeat (2) @(negedge sclk);
        if (mode != 2'h1) begin
          rsp = {2'b00, idx ^ {5'h0, mode[1]}, arg, 7'h7F, 1'b1};
          for (int i = 47; i >= 0; i--) begin
            @(negedge sclk);
            line = rsp[i];
            if (i == 0 && idx inside {6'h1C, 6'h1D, 6'h26, 6'h2A, 6'h38}) busy_end = falls + 5;
          end
          @(negedge sclk);
          line = 1'b1;
        end
      end
    end
  end
endmodule

// ---- tb_sdc_cmd_upper.sv ----
// self-checking bench of the upper card command interpreter
`timescale 1ns/1ps
module tb_sdc_cmd_upper;
  // ------------------------------
  // signals and cases
  // ------------------------------
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic data_done = 1'b0;
  logic sd_clk = 1'b0;
  logic en = 1'b0;
  logic [1:0] mode = 2'h0;
  logic req_ready, done, refused, busy_pending, data_start, data_dir, cmd_o, cmd_oe_n;
  logic card_line, dat0, seen_data;
  logic [47:0] frame;
  logic [47:0] f;
  sdc_pkg::sdc_req_t req = '0;
  sdc_pkg::sdc_answer_t answer;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  typedef struct packed {
    logic [5:0] idx; logic [31:0] addr; logic wf; logic [7:0] wd; logic dir; logic [31:0] st;
  } sdc_row_t;
  sdc_row_t rows [12] = '{
    '{6'h1C, 32'h10, 1'b0, 8'h00, 1'b0, 32'h10}, '{6'h1D, 32'h10, 1'b0, 8'h00, 1'b0, 32'h10},
    '{6'h1E, 32'h2000, 1'b0, 8'h00, 1'b0, 32'h2000}, '{6'h23, 32'h100, 1'b0, 8'h00, 1'b0, 32'h100},
    '{6'h24, 32'h200, 1'b0, 8'h00, 1'b0, 32'h200}, '{6'h26, '1, 1'b0, 8'h00, 1'b0, 32'h0},
    '{6'h27, '1, 1'b1, 8'hA5, 1'b0, 32'h123485A5}, '{6'h27, '1, 1'b0, 8'h00, 1'b0, 32'h123405A5},
    '{6'h28, '1, 1'b0, 8'h00, 1'b0, 32'h0}, '{6'h2A, '1, 1'b0, 8'h00, 1'b1, 32'h0},
    '{6'h37, '1, 1'b0, 8'h00, 1'b0, 32'h12340000}, '{6'h38, '1, 1'b0, 8'h00, 1'b1, 32'h1}};
  logic [5:0] ill [13] = '{6'h1F, 6'h20, 6'h21, 6'h22, 6'h25, 6'h29, 6'h2B, 6'h36, 6'h39,
    6'h3B, 6'h3C, 6'h3F, 6'h1B};

  sdc_cmd_upper dut (.ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .done(done), .refused(refused), .answer(answer),
    .busy_pending(busy_pending), .data_start(data_start), .data_dir(data_dir),
    .data_done(data_done), .sd_clk(sd_clk), .cmd_i(cmd_oe_n ? card_line : cmd_o),
    .cmd_o(cmd_o), .cmd_oe_n(cmd_oe_n), .dat0_i(dat0));
  sdc_card_model card (.sclk(sd_clk), .host_bit(cmd_o), .host_drive_n(cmd_oe_n),
    .mode(mode), .line(card_line), .dat0(dat0), .frame(frame));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // link clock stands low between commands
  initial begin
    #7;
    forever #160 sd_clk = en ? ~sd_clk : 1'b0;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      final_report();
    end
  end

  task automatic final_report();
    $display("errors=%0d checks=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] pack(input sdc_row_t r);
    case (r.idx)
      6'h27: pack = {16'h1234, r.wf, 7'h05, r.wd};
      6'h37: pack = 32'h12340000;
      6'h38: pack = {31'h0, r.dir};
      6'h26, 6'h28, 6'h2A: pack = 32'h0;
      default: pack = r.addr;
    endcase
  endfunction
  // frame check code, most significant bit first, x^7+x^3+1
  function automatic logic [6:0] crc_ref(input logic [39:0] b);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ({7{c[6] ^ b[i]}} & 7'h09);
    end
    return c;
  endfunction
  task automatic run(input logic [5:0] i, input logic [31:0] a, input logic w,
    input logic [7:0] d, input logic r);
    int k;
    // one edge between requests so no strobe is set twice in a time step
    @(posedge ref_clk);
    #1 req = '{i, a, 16'h1234, w, 7'h05, d, r};
    en = 1'b1;
    seen_data = 1'b0;
    req_valid = 1'b1;
    k = 0;
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    #1 req_valid = 1'b0;
    while (done !== 1'b1 && refused !== 1'b1 && k < 3000) begin
      @(posedge ref_clk);
      #1 k++;
      data_done = (data_start === 1'b1);
      if (data_start === 1'b1) seen_data = 1'b1;
    end
  endtask
  task automatic settle();
    int k;
    k = 0;
    while (busy_pending !== 1'b0 && k < 500) begin
      @(posedge ref_clk);
      #1 k++;
    end
    chk(busy_pending, 1'b0);
    repeat (20) @(posedge ref_clk);
    #1 en = 1'b0;
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    chk({req_ready, done, refused, busy_pending, cmd_o, cmd_oe_n, data_start}, 7'b1000110);
    #1 rstn = 1'b1;
    foreach (rows[i]) begin
      run(rows[i].idx, rows[i].addr, rows[i].wf, rows[i].wd, rows[i].dir);
      f = {2'b01, rows[i].idx, pack(rows[i]), 8'h01};
      f[7:1] = crc_ref(f[47:8]);
      chk(frame, f);
      chk({answer, done}, {rows[i].idx, rows[i].st, 1'b0, 1'b1});
      chk({seen_data, data_dir}, {rows[i].idx inside {6'h1E, 6'h2A, 6'h38}, rows[i].dir});
      settle();
    end
    foreach (ill[i]) begin
      f = frame;
      run(ill[i], 32'h0, 1'b0, 8'h00, 1'b0);
      chk({refused, done, frame}, {2'b10, f});
      en = 1'b0;
    end
    run(6'h1C, 32'h11, 1'b0, 8'h00, 1'b0);
    req.index = 6'h1E;
    req_valid = 1'b1;
    // held across an edge: the stalled data command must not be taken
    @(posedge ref_clk);
    #1 chk({busy_pending, req_ready, done, refused}, 4'b1000);
    req_valid = 1'b0;
    settle();
    chk(req_ready, 1'b1);
    mode = 2'h1;
    run(6'h23, 32'h5, 1'b0, 8'h00, 1'b0);
    chk({done, answer.err}, 2'b11);
    mode = 2'h2;
    settle();
    run(6'h23, 32'h5, 1'b0, 8'h00, 1'b0);
    chk({done, answer.index, answer.err}, {1'b1, 6'h22, 1'b1});
    mode = 2'h0;
    settle();
    final_report();
  end
endmodule
